// file: hw/ddc_nco_pkg.sv
package ddc_nco_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [11:0] ADDR_ROUTING = 12'h370;
  localparam logic [11:0] ADDR_CTRL = 12'h374;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_SEL_LSB = 0;
  localparam int ROUTE_Q_BIT = 2;
  localparam int ROUTE_I_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic ROUTE_Q_RESET = 1'b1;
  localparam logic ROUTE_I_RESET = 1'b1;
  localparam logic [3:0] COUNT_RESET = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Channel select modes
  typedef enum logic [3:0] {
    MODE_REG = 4'h0,
    MODE_B0_A0 = 4'h1,
    MODE_B1_A1 = 4'h2,
    MODE_A1_A0 = 4'h3,
    MODE_B1_B0 = 4'h4,
    MODE_B1_A1_B0_A0 = 4'h5,
    MODE_B1_B0_A1_A0 = 4'h6,
    MODE_EDGE_A0 = 4'h8,
    MODE_EDGE_A1 = 4'h9,
    MODE_EDGE_B0 = 4'hA,
    MODE_EDGE_B1 = 4'hB
  } sel_mode_t;

  localparam logic [1:0] EDGE_GROUP = 2'h2;

endpackage

// file: hw/nco_sel_if.sv
`timescale 1ns/1ps
interface nco_sel_if;
  logic [3:0] mode;
  logic [3:0] map_sel;
  logic [3:0] active;

  modport ctrl (
    output mode,
    output map_sel,
    input active
  );

  modport sel (
    input mode,
    input map_sel,
    output active
  );
endinterface

// file: hw/nco_channel_picker.sv
`timescale 1ns/1ps
module nco_channel_picker (
  input wire logic mclk,
  input wire logic rst_n,
  nco_sel_if.sel bus,
  input wire logic select_pin_a_bit0,
  input wire logic select_pin_a_bit1,
  input wire logic select_pin_b_bit0,
  input wire logic select_pin_b_bit1
);

  function automatic logic is_edge_mode(input logic [3:0] m);
    return m[3:2] == ddc_nco_pkg::EDGE_GROUP;
  endfunction

  logic [3:0] pins;
  logic [3:0] pins_prev;
  logic [3:0] count;
  logic [3:0] next_active;
  logic rise;

  // Index: 0 a0, 1 a1, 2 b0, 3 b1
  assign pins = {select_pin_b_bit1, select_pin_b_bit0, select_pin_a_bit1, select_pin_a_bit0};
  assign rise = pins[bus.mode[1:0]] & ~pins_prev[bus.mode[1:0]]; // (R3)

  ////////////////////////////////////////////////////////////////////////////
  // Pin history for edge detection
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pins_prev <= 4'h0;
    end else begin
      pins_prev <= pins;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge-stepped counter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= ddc_nco_pkg::COUNT_RESET;
    end else if (!is_edge_mode(bus.mode)) begin
      count <= ddc_nco_pkg::COUNT_RESET;
    end else if (rise) begin
      if (count >= bus.map_sel) begin
        count <= ddc_nco_pkg::COUNT_RESET; // (R4)
      end else begin
        count <= count + 4'h1; // (R3)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active channel choice
  always_comb begin
    unique case (ddc_nco_pkg::sel_mode_t'(bus.mode))
      ddc_nco_pkg::MODE_REG: next_active = bus.map_sel; // (R1)
      ddc_nco_pkg::MODE_B0_A0: next_active = {2'h0, pins[2], pins[0]}; // (R2)
      ddc_nco_pkg::MODE_B1_A1: next_active = {2'h0, pins[3], pins[1]}; // (R2)
      ddc_nco_pkg::MODE_A1_A0: next_active = {2'h0, pins[1], pins[0]}; // (R2)
      ddc_nco_pkg::MODE_B1_B0: next_active = {2'h0, pins[3], pins[2]}; // (R2)
      ddc_nco_pkg::MODE_B1_A1_B0_A0: next_active = {pins[3], pins[1], pins[2], pins[0]}; // (R2)
      ddc_nco_pkg::MODE_B1_B0_A1_A0: next_active = pins; // (R2)
      ddc_nco_pkg::MODE_EDGE_A0,
      ddc_nco_pkg::MODE_EDGE_A1,
      ddc_nco_pkg::MODE_EDGE_B0,
      ddc_nco_pkg::MODE_EDGE_B1: next_active = count; // (R3)
      default: next_active = bus.map_sel;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus.active <= ddc_nco_pkg::SEL_RESET;
    end else begin
      bus.active <= next_active;
    end
  end

endmodule

// file: hw/ddc_nco_channel_select.sv
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
// Summary of operation
// (R1) Mode 0000 takes the active channel from the register select field.
// (R2) Modes 0001-0110 build the active channel from select pin levels.
// (R3) Modes 1000-1011 step a counter on rising edges of A0, A1, B0, B1.
// (R4) The edge counter wraps to zero on the edge after it reaches the register select field.
// (R5) The register select field names the channel software accesses.
// (R6) Mode and select fields reset to zero.
// (R7) Q select bit 2, I select bit 0: 0 channel A, 1 B; reset 1.
module ddc_nco_channel_select (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic select_pin_a_bit0,
  input wire logic select_pin_a_bit1,
  input wire logic select_pin_b_bit0,
  input wire logic select_pin_b_bit1,
  output logic [3:0] active_nco_channel,
  output logic [3:0] access_nco_channel,
  output logic i_input_sel,
  output logic q_input_sel
);

  nco_sel_if sel_bus ();

  logic [3:0] mode;
  logic write_go;
  logic low_lane;
  logic [7:0] next_readdata;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon handshake: one wait cycle, then the request completes
  assign write_go = avs_write & ~avs_waitrequest;
  assign low_lane = avs_byteenable[0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_comb begin
    next_readdata = 8'h00;
    if (avs_address == ddc_nco_pkg::ADDR_CTRL) begin
      next_readdata = {mode, access_nco_channel};
    end else if (avs_address == ddc_nco_pkg::ADDR_ROUTING) begin
      next_readdata = {5'h00, q_input_sel, 1'b0, i_input_sel}; // (R7)
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, next_readdata};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator channel control register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= ddc_nco_pkg::MODE_RESET; // (R6)
      access_nco_channel <= ddc_nco_pkg::SEL_RESET; // (R6)
    end else if (write_go && low_lane && avs_address == ddc_nco_pkg::ADDR_CTRL) begin
      mode <= avs_writedata[ddc_nco_pkg::CTRL_MODE_LSB +: 4];
      access_nco_channel <= avs_writedata[ddc_nco_pkg::CTRL_SEL_LSB +: 4]; // (R5)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input routing register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_input_sel <= ddc_nco_pkg::ROUTE_Q_RESET; // (R7)
      i_input_sel <= ddc_nco_pkg::ROUTE_I_RESET; // (R7)
    end else if (write_go && low_lane && avs_address == ddc_nco_pkg::ADDR_ROUTING) begin
      q_input_sel <= avs_writedata[ddc_nco_pkg::ROUTE_Q_BIT]; // (R7)
      i_input_sel <= avs_writedata[ddc_nco_pkg::ROUTE_I_BIT]; // (R7)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active channel selection
  assign sel_bus.mode = mode;
  assign sel_bus.map_sel = access_nco_channel;
  assign active_nco_channel = sel_bus.active;

  nco_channel_picker u_picker (
    .mclk(mclk),
    .rst_n(rst_n),
    .bus(sel_bus.sel),
    .select_pin_a_bit0(select_pin_a_bit0),
    .select_pin_a_bit1(select_pin_a_bit1),
    .select_pin_b_bit0(select_pin_b_bit0),
    .select_pin_b_bit1(select_pin_b_bit1)
  );

endmodule

// file: test/ddc_nco_checker_assertions.sv
`timescale 1ns/1ps
module ddc_nco_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] avs_address,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic select_pin_a_bit0,
  input wire logic select_pin_a_bit1,
  input wire logic select_pin_b_bit0,
  input wire logic select_pin_b_bit1,
  input wire logic [3:0] active_nco_channel,
  input wire logic [3:0] access_nco_channel,
  input wire logic i_input_sel,
  input wire logic q_input_sel
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic [9:0] regs;
  wire [3:0] act = active_nco_channel;
  wire [3:0] mode = regs[7:4];
  wire [3:0] pin5 = {select_pin_b_bit1, select_pin_a_bit1, select_pin_b_bit0, select_pin_a_bit0};
  wire wr = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[11:4] == 8'h37;
  // Shadow of routing bits and control byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regs <= 10'h300;
    end else if (wr && avs_address[3:0] == 4'h4) begin
      regs[7:0] <= avs_writedata[7:0];
    end else if (wr && avs_address[3:0] == 4'h0) begin
      regs[9:8] <= {avs_writedata[2], avs_writedata[0]};
    end
  end
  property p_reg;
    mode == 4'h0 |=> act == $past(access_nco_channel);
  endproperty
  a_reg: assert property (p_reg) else $error("register mode channel");
  property p_pins;
    mode == 4'h5 |=> act == $past(pin5);
  endproperty
  a_pins: assert property (p_pins) else $error("pin mode channel");
  property p_step;
    mode == 4'h8 && $past(mode, 2) == 4'h8 && $rose(select_pin_a_bit0) &&
      act < access_nco_channel |-> ##2 act == $past(act, 2) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("counter step");
  property p_wrap;
    mode == 4'h8 && $past(mode, 2) == 4'h8 && $rose(select_pin_a_bit0) &&
      act >= access_nco_channel |-> ##2 act == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter wrap");
  property p_sel;
    access_nco_channel == regs[3:0];
  endproperty
  a_sel: assert property (p_sel) else $error("access channel");
  property p_rst;
    $rose(rst_n) |-> act == 4'h0 && access_nco_channel == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset channel");
  property p_route;
    {q_input_sel, i_input_sel} == regs[9:8];
  endproperty
  a_route: assert property (p_route) else $error("input routing");
  c_wrap: cover property (mode == 4'h8 && $rose(select_pin_a_bit0) && act == 4'h0);
  c_pins: cover property (mode == 4'h5);
  c_route: cover property (wr && avs_address[3:0] == 4'h0);
endmodule
bind ddc_nco_channel_select ddc_nco_checker ddc_nco_checker_i (.*);

// file: test/pin_driver.sv
`timescale 1ns/1ps
module pin_driver (
  input wire logic mclk,
  output logic select_pin_a_bit0,
  output logic select_pin_a_bit1,
  output logic select_pin_b_bit0,
  output logic select_pin_b_bit1
);
  logic [3:0] p = 4'h0;
  assign {select_pin_b_bit1, select_pin_b_bit0, select_pin_a_bit1, select_pin_a_bit0} = p;
  task automatic set(input logic [3:0] v);
    @(posedge mclk);
    p <= v;
  endtask
  task automatic pulse(input int k);
    @(posedge mclk);
    p[k] <= 1'h1;
    @(posedge mclk);
    p[k] <= 1'h0;
  endtask
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hF, active_nco_channel, access_nco_channel, e;
  logic avs_waitrequest, i_input_sel, q_input_sel;
  wire select_pin_a_bit0, select_pin_a_bit1, select_pin_b_bit0, select_pin_b_bit1;
  int fails = 0, n_compared = 0, cyc = 0;
  always #20 mclk = ~mclk;
  pin_driver pin_driver_i (.*);
  ddc_nco_channel_select ddc_nco_channel_select_i (.*);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'h0) @(posedge mclk);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  ////////////////////////////////////////
  task t_reset;
    bus(1'h0, 12'h370, 8'h00);
    chk(rd, 32'h5);
    bus(1'h0, 12'h3F0, 8'h00);
    chk(rd, 32'h0);
    chk({active_nco_channel, access_nco_channel, q_input_sel, i_input_sel}, 10'h003);
  endtask
  task t_route;
    for (int k = 0; k < 2; k++) begin
      bus(1'h1, 12'h370, k ? 8'h03 : 8'hFE);
      bus(1'h0, 12'h370, 8'h00);
      chk(rd, k ? 32'h1 : 32'h4);
      chk({q_input_sel, i_input_sel}, k ? 2'h1 : 2'h2);
    end
    // A write without the low byte lane must leave the register alone
    @(posedge mclk);
    avs_byteenable <= 4'hE;
    bus(1'h1, 12'h370, 8'hFE);
    avs_byteenable <= 4'hF;
    bus(1'h0, 12'h370, 8'h00);
    chk(rd, 32'h1);
    chk({q_input_sel, i_input_sel}, 2'h1);
  endtask
  task t_reg;
    for (int k = 0; k < 3; k++) begin
      bus(1'h1, 12'h374, 8'h07 + k[7:0]);
      bus(1'h0, 12'h374, 8'h00);
      chk(rd, 32'h7 + k);
      chk(access_nco_channel, 4'h7 + k[3:0]);
      chk(active_nco_channel, 4'h7 + k[3:0]);
    end
    // Undefined mode codes fall back to the register select field
    for (int k = 0; k < 2; k++) begin
      bus(1'h1, 12'h374, k ? 8'hC5 : 8'h75);
      repeat (2) @(posedge mclk);
      chk(active_nco_channel, 4'h5);
    end
  endtask
  task t_lvl;
    for (int m = 1; m < 7; m++) begin
      for (int k = 0; k < 2; k++) begin
        e = k ? 4'h6 : 4'hA;
        bus(1'h1, 12'h374, {m[3:0], 4'h0});
        pin_driver_i.set(e);
        repeat (2) @(posedge mclk);
        case (m)
          1: e = {2'h0, e[2], e[0]};
          2: e = {2'h0, e[3], e[1]};
          3: e = {2'h0, e[1], e[0]};
          4: e = {2'h0, e[3], e[2]};
          5: e = {e[3], e[1], e[2], e[0]};
          default: e = e;
        endcase
        chk(active_nco_channel, e);
      end
    end
  endtask
  task t_edge;
    for (int m = 8; m < 12; m++) begin
      // Leave the edge modes so the counter restarts from zero
      bus(1'h1, 12'h374, 8'h02);
      pin_driver_i.set(4'h0);
      bus(1'h1, 12'h374, {m[3:0], 4'h2});
      e = 4'h0;
      for (int n = 0; n < 5; n++) begin
        repeat (2) @(posedge mclk);
        chk(active_nco_channel, e);
        pin_driver_i.pulse(m - 8);
        e = (e >= 4'h2) ? 4'h0 : e + 4'h1;
      end
    end
  endtask
  ////////////////////////////////////////
  task print_verdict;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      print_verdict;
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'h1;
    t_reset;
    t_route;
    t_reg;
    t_lvl;
    t_edge;
    print_verdict;
  end
endmodule
